// ### core/cpt_pkg.sv
// constants for the cascadable pwm timer counter
package cpt_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] CPT_ADDR_CTRL_LO  = 8'h00;
    localparam logic [7:0] CPT_ADDR_CTRL_HI  = 8'h04;
    localparam logic [7:0] CPT_ADDR_CMP_LO   = 8'h08;
    localparam logic [7:0] CPT_ADDR_CMP_HI   = 8'h0C;
    localparam logic [7:0] CPT_ADDR_DUTY_LO  = 8'h10;
    localparam logic [7:0] CPT_ADDR_DUTY_HI  = 8'h14;
    localparam logic [7:0] CPT_ADDR_CLKCFG   = 8'h18;
    localparam logic [7:0] CPT_ADDR_COUNT_LO = 8'h1C;
    localparam logic [7:0] CPT_ADDR_COUNT_HI = 8'h20;

    // unit control register fields
    localparam int CPT_CTRL_FF_BIT   = 7;
    localparam int CPT_CTRL_SRC_MSB  = 6;
    localparam int CPT_CTRL_SRC_LSB  = 4;
    localparam int CPT_CTRL_RUN_BIT  = 3;
    localparam int CPT_CTRL_MODE_MSB = 2;
    localparam int CPT_CTRL_MODE_LSB = 0;

    // clock configuration register fields
    localparam int CPT_CFG_DIVSEL_BIT = 0;
    localparam int CPT_CFG_SLOW_BIT   = 1;

    // operating modes
    localparam logic [2:0] CPT_MODE_PWM8    = 3'h2;
    localparam logic [2:0] CPT_MODE_TIMER16 = 3'h3;

    // source clock selections
    localparam logic [2:0] CPT_SRC_DIV2048 = 3'h0;
    localparam logic [2:0] CPT_SRC_DIV128  = 3'h1;
    localparam logic [2:0] CPT_SRC_DIV32   = 3'h2;
    localparam logic [2:0] CPT_SRC_DIV8    = 3'h3;
    localparam logic [2:0] CPT_SRC_LOWFREQ = 3'h4;
    localparam logic [2:0] CPT_SRC_DIV2    = 3'h5;
    localparam logic [2:0] CPT_SRC_DIV1    = 3'h6;

    // prescaler tap widths, divide by two to the power
    localparam int CPT_PRE_W      = 11;
    localparam int CPT_TAP_2048   = 11;
    localparam int CPT_TAP_128    = 7;
    localparam int CPT_TAP_32     = 5;
    localparam int CPT_TAP_8      = 3;
    localparam int CPT_FS_DIV_W   = 3;

    // reset values and counter limits
    localparam logic [7:0] CPT_CTRL_RST  = 8'h00;
    localparam logic [7:0] CPT_DUTY_RST  = 8'h00;
    localparam logic [7:0] CPT_CMP_RST   = 8'h00;
    localparam logic [1:0] CPT_CFG_RST   = 2'h0;
    localparam logic [7:0] CPT_CNT_RST   = 8'h00;
    localparam logic [7:0] CPT_CNT_MAX   = 8'hFF;
    localparam logic       CPT_FF_RST    = 1'b0;

endpackage : cpt_pkg

// ### core/cpt_timer.sv
// two cascadable 8-bit counter units with pwm outputs and a wishbone slave
`timescale 1ns/10ps
module cpt_timer
    import cpt_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        low_freq_clock,
    output logic             pwm_out_pin_low,
    output logic             pwm_out_pin_high,
    output logic             unit_timer_irq_low,
    output logic             high_unit_timer_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [1:0][7:0]         ctrl_q;
    logic [1:0][7:0]         ctrl_d;
    logic [1:0][7:0]         cnt_q;
    logic [1:0][7:0]         cnt_d;
    logic [1:0][7:0]         duty_hold_q;
    logic [1:0][7:0]         duty_hold_d;
    logic [1:0][7:0]         duty_act_q;
    logic [1:0][7:0]         duty_act_d;
    logic [1:0][7:0]         cmp_q;
    logic [1:0][7:0]         cmp_d;
    logic [1:0]              ff_q;
    logic [1:0]              ff_d;
    logic [1:0]              irq_q;
    logic [1:0]              irq_d;
    logic [1:0]              cfg_q;
    logic [1:0]              cfg_d;
    logic [CPT_PRE_W-1:0]    pre_q;
    logic [CPT_PRE_W-1:0]    pre_d;
    logic [CPT_FS_DIV_W-1:0] fsdiv_q;
    logic [CPT_FS_DIV_W-1:0] fsdiv_d;
    logic                    fs_s1_q;
    logic                    fs_s2_q;
    logic                    fs_s3_q;
    logic                    ack_q;
    logic                    ack_d;
    logic [31:0]             dat_q;
    logic [31:0]             dat_d;

    logic                    fs_tick;
    logic                    fs8_tick;
    logic [1:0]              tick;
    logic                    bus_req;
    logic                    bus_wr;
    logic [7:0]              rd_byte;
    logic                    t16_mode;
    logic [15:0]             cnt16_inc;

    ////////////////////////////////////////////////////////////////////////////
    // source clocks

    // slow clock arrives from a pin, so only the second and third stages feed edge logic
    assign fs_tick  = fs_s2_q & ~fs_s3_q;
    assign fs8_tick = fs_tick & (&fsdiv_q);

    // prescaler free-runs; each tap is an all-ones decode, one pulse per period
    always_comb begin
        pre_d   = pre_q + 1'b1;
        fsdiv_d = fs_tick ? fsdiv_q + 1'b1 : fsdiv_q;
    end

    genvar gu;
    generate
        for (gu = 0; gu < 2; gu++) begin : g_src
            // decoded per unit so the two units may run from different rates
            logic [2:0] src;
            assign src = ctrl_q[gu][CPT_CTRL_SRC_MSB:CPT_CTRL_SRC_LSB];
            always_comb begin
                tick[gu] = 1'b0;
                if (cfg_q[CPT_CFG_SLOW_BIT]) begin
                    // slow mode: fast clock taps are dead
                    case (src)
                        CPT_SRC_DIV2048: tick[gu] = fs8_tick;
                        CPT_SRC_LOWFREQ: tick[gu] = fs_tick;
                        default:         tick[gu] = 1'b0;
                    endcase
                end else begin
                    case (src)
                        CPT_SRC_DIV2048: tick[gu] = cfg_q[CPT_CFG_DIVSEL_BIT] ? fs8_tick
                                                  : &pre_q[CPT_TAP_2048-1:0];
                        CPT_SRC_DIV128:  tick[gu] = &pre_q[CPT_TAP_128-1:0];
                        CPT_SRC_DIV32:   tick[gu] = &pre_q[CPT_TAP_32-1:0];
                        CPT_SRC_DIV8:    tick[gu] = &pre_q[CPT_TAP_8-1:0];
                        CPT_SRC_LOWFREQ: tick[gu] = fs_tick;
                        CPT_SRC_DIV2:    tick[gu] = pre_q[0];
                        CPT_SRC_DIV1:    tick[gu] = 1'b1;
                        default:         tick[gu] = 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    // only byte lane 0 carries register data; the other lanes are ignored
    assign bus_req   = wb_cyc_i & wb_stb_i;
    // a write lands on the edge where the master sees ack
    assign bus_wr    = bus_req & wb_we_i & ack_q & wb_sel_i[0];
    assign t16_mode  = ctrl_q[0][CPT_CTRL_MODE_MSB:CPT_CTRL_MODE_LSB] == CPT_MODE_TIMER16;
    assign cnt16_inc = {cnt_q[1], cnt_q[0]} + 16'h0001;

    always_comb begin
        case (wb_adr_i)
            CPT_ADDR_CTRL_LO:  rd_byte = ctrl_q[0];
            CPT_ADDR_CTRL_HI:  rd_byte = ctrl_q[1];
            CPT_ADDR_CMP_LO:   rd_byte = cmp_q[0];
            CPT_ADDR_CMP_HI:   rd_byte = cmp_q[1];
            CPT_ADDR_DUTY_LO:  rd_byte = duty_act_q[0];
            CPT_ADDR_DUTY_HI:  rd_byte = duty_act_q[1];
            CPT_ADDR_CLKCFG:   rd_byte = {6'h00, cfg_q};
            CPT_ADDR_COUNT_LO: rd_byte = cnt_q[0];
            CPT_ADDR_COUNT_HI: rd_byte = cnt_q[1];
            default:           rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        ack_d = bus_req & ~ack_q;
        dat_d = ack_d ? {24'h000000, rd_byte} : dat_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // counters, flip-flops and registers

    // no power-down input: a unit left running keeps ticking, software stops it
    always_comb begin
        ctrl_d      = ctrl_q;
        cnt_d       = cnt_q;
        duty_hold_d = duty_hold_q;
        duty_act_d  = duty_act_q;
        cmp_d       = cmp_q;
        ff_d        = ff_q;
        irq_d       = 2'b00;
        cfg_d       = cfg_q;

        if (t16_mode) begin
            if (!ctrl_q[1][CPT_CTRL_RUN_BIT]) begin
                // stopped timer sits at zero so the first period is whole
                cnt_d[0] = CPT_CNT_RST;
                cnt_d[1] = CPT_CNT_RST;
            end else if (tick[0]) begin
                // the cascade borrows the low unit's source select
                // compare is read live, no shadow stage
                if (cnt16_inc == {cmp_q[1], cmp_q[0]}) begin
                    cnt_d[0] = CPT_CNT_RST;
                    cnt_d[1] = CPT_CNT_RST;
                    irq_d[1] = 1'b1;
                end else begin
                    cnt_d[0] = cnt16_inc[7:0];
                    cnt_d[1] = cnt16_inc[15:8];
                end
            end
        end else begin
            for (int u = 0; u < 2; u++) begin
                if (!ctrl_q[u][CPT_CTRL_RUN_BIT]) begin
                    // stopping leaves the flip-flop, so the pin holds
                    cnt_d[u] = CPT_CNT_RST;
                end else if (ctrl_q[u][CPT_CTRL_MODE_MSB:CPT_CTRL_MODE_LSB] == CPT_MODE_PWM8
                             && tick[u]) begin
                    // duty match and overflow together cancel out
                    ff_d[u] = ff_q[u] ^ ((cnt_q[u] == duty_act_q[u])
                                       ^ (cnt_q[u] == CPT_CNT_MAX));
                    if (cnt_q[u] == CPT_CNT_MAX) begin
                        cnt_d[u]      = CPT_CNT_RST;
                        irq_d[u]      = 1'b1;
                        duty_act_d[u] = duty_hold_q[u];
                    end else begin
                        cnt_d[u] = cnt_q[u] + 8'h01;
                    end
                end
            end
        end

        if (bus_wr) begin
            case (wb_adr_i)
                CPT_ADDR_CTRL_LO, CPT_ADDR_CTRL_HI: begin
                    for (int u = 0; u < 2; u++) begin
                        if (wb_adr_i == (u == 0 ? CPT_ADDR_CTRL_LO : CPT_ADDR_CTRL_HI)) begin
                            ctrl_d[u] = wb_dat_i[7:0];
                            // the write that stops may not move the level
                            if (!ctrl_q[u][CPT_CTRL_RUN_BIT]) begin
                                ff_d[u] = wb_dat_i[CPT_CTRL_FF_BIT];
                            end
                        end
                    end
                end
                CPT_ADDR_DUTY_LO, CPT_ADDR_DUTY_HI: begin
                    for (int u = 0; u < 2; u++) begin
                        if (wb_adr_i == (u == 0 ? CPT_ADDR_DUTY_LO : CPT_ADDR_DUTY_HI)) begin
                            // a write in the interrupt cycle waits for the next one
                            duty_hold_d[u] = wb_dat_i[7:0];
                            if (!ctrl_q[u][CPT_CTRL_RUN_BIT]) begin
                                duty_act_d[u] = wb_dat_i[7:0];
                            end
                        end
                    end
                end
                CPT_ADDR_CMP_LO: begin
                    cmp_d[0] = wb_dat_i[7:0];
                end
                CPT_ADDR_CMP_HI: begin
                    cmp_d[1] = wb_dat_i[7:0];
                end
                CPT_ADDR_CLKCFG: begin
                    cfg_d = wb_dat_i[1:0];
                end
                default: begin
                    cfg_d = cfg_q;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // every state bit sits behind the one asynchronous reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q      <= {2{CPT_CTRL_RST}};
            cnt_q       <= {2{CPT_CNT_RST}};
            duty_hold_q <= {2{CPT_DUTY_RST}};
            duty_act_q  <= {2{CPT_DUTY_RST}};
            cmp_q       <= {2{CPT_CMP_RST}};
            ff_q        <= {2{CPT_FF_RST}};
            irq_q       <= 2'b00;
            cfg_q       <= CPT_CFG_RST;
            pre_q       <= '0;
            fsdiv_q     <= '0;
            fs_s1_q     <= 1'b0;
            fs_s2_q     <= 1'b0;
            fs_s3_q     <= 1'b0;
            ack_q       <= 1'b0;
            dat_q       <= 32'h00000000;
        end else begin
            ctrl_q      <= ctrl_d;
            cnt_q       <= cnt_d;
            duty_hold_q <= duty_hold_d;
            duty_act_q  <= duty_act_d;
            cmp_q       <= cmp_d;
            ff_q        <= ff_d;
            irq_q       <= irq_d;
            cfg_q       <= cfg_d;
            pre_q       <= pre_d;
            fsdiv_q     <= fsdiv_d;
            fs_s1_q     <= low_freq_clock;
            fs_s2_q     <= fs_s1_q;
            fs_s3_q     <= fs_s2_q;
            ack_q       <= ack_d;
            dat_q       <= dat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // pins are a plain inverter after the flop, so reset shows a clean high
    assign wb_ack_o            = ack_q;
    assign wb_dat_o            = dat_q;
    assign pwm_out_pin_low     = ~ff_q[0];
    assign pwm_out_pin_high    = ~ff_q[1];
    assign unit_timer_irq_low  = irq_q[0];
    assign high_unit_timer_irq = irq_q[1];

endmodule : cpt_timer

// ### sim/cpt_timer_checker.sv
// concurrent checks on the ports of the pwm timer counter
`timescale 1ns/10ps
module cpt_timer_checker
    import cpt_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_we_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        low_freq_clock,
    input wire logic        pwm_out_pin_low,
    input wire logic        pwm_out_pin_high,
    input wire logic        unit_timer_irq_low,
    input wire logic        high_unit_timer_irq
);
    logic run_lo_q;
    logic run_lo_d;
    logic ctl_wr;
    ////////////////////////////////////////////////////////////////////////
    // shadow of the low unit run bit, seen from completed bus writes
    assign ctl_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && (wb_adr_i == CPT_ADDR_CTRL_LO);
    always_comb begin
        run_lo_d = ctl_wr ? wb_dat_i[CPT_CTRL_RUN_BIT] : run_lo_q;
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            run_lo_q <= 1'b0;
        end else begin
            run_lo_q <= run_lo_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_stop_write;
        ctl_wr && run_lo_q && !wb_dat_i[CPT_CTRL_RUN_BIT];
    endsequence
    sequence s_idle_write;
        ctl_wr && !run_lo_q;
    endsequence
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged one cycle later");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_read_narrow: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_reset_pins: assert property (@(posedge sys_clk) disable iff (1'b0)
        !reset_n |-> pwm_out_pin_low && pwm_out_pin_high && !unit_timer_irq_low)
        else $error("pins or irq wrong during reset");
    a_irq_toggles: assert property (unit_timer_irq_low |-> pwm_out_pin_low != $past(pwm_out_pin_low))
        else $error("overflow did not toggle the pin");
    a_irq_gap_low: assert property (unit_timer_irq_low |=> !unit_timer_irq_low [*8])
        else $error("low unit irq too close");
    a_irq_gap_high: assert property (high_unit_timer_irq |=> !high_unit_timer_irq [*7])
        else $error("high unit irq too close");
    // the next bus write may legally reload the level, so only two cycles are held
    a_stop_holds: assert property (s_stop_write |-> ##2 $stable(pwm_out_pin_low) [*2])
        else $error("pin moved after stop");
    a_ff_load: assert property (s_idle_write |=> pwm_out_pin_low == !$past(wb_dat_i[CPT_CTRL_FF_BIT]))
        else $error("flip-flop start level not loaded");
endmodule : cpt_timer_checker

bind cpt_timer cpt_timer_checker cpt_timer_checker_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .low_freq_clock(low_freq_clock), .pwm_out_pin_low(pwm_out_pin_low),
    .pwm_out_pin_high(pwm_out_pin_high), .unit_timer_irq_low(unit_timer_irq_low),
    .high_unit_timer_irq(high_unit_timer_irq));

// ### sim/cpt_pwm_meter.sv
// external load on a pwm pin: measures low width and period in clocks
`timescale 1ns/10ps
module cpt_pwm_meter (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        pin_level,
    output logic      [15:0] low_width,
    output logic      [15:0] period
);
    logic        prev_q;
    logic [15:0] cnt_q;
    // pin is only read, the port latch is assumed set to 1
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q    <= 1'b1;
            cnt_q     <= 16'h0000;
            low_width <= 16'h0000;
            period    <= 16'h0000;
        end else begin
            prev_q <= pin_level;
            cnt_q  <= (prev_q && !pin_level) ? 16'h0001 : cnt_q + 16'h0001;
            if (prev_q && !pin_level) begin
                period <= cnt_q;
            end
            if (!prev_q && pin_level) begin
                low_width <= cnt_q;
            end
        end
    end
endmodule : cpt_pwm_meter

// ### sim/tb_top.sv
// self-checking testbench for the pwm timer counter
`timescale 1ns/10ps
module tb_top
    import cpt_pkg::*;
;
    logic sys_clk, reset_n, wb_we_i, wb_cyc_i, wb_stb_i, low_freq_clock, wb_ack_o;
    logic pwm_out_pin_low, pwm_out_pin_high, unit_timer_irq_low, high_unit_timer_irq;
    logic [7:0]  wb_adr_i, rd, duty_a;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [3:0]  wb_sel_i;
    logic [15:0] low_width, period, cmp;
    logic [2:0]  slow_cnt;
    int          n_mismatch, comparisons, cycles, gap;
    integer      seed;
    logic [2:0]  srcs [5] = '{CPT_SRC_DIV1, CPT_SRC_DIV2, CPT_SRC_DIV8, CPT_SRC_LOWFREQ,
                              CPT_SRC_DIV32};
    int          divs [5] = '{1, 2, 8, 10, 32};
    cpt_timer cpt_timer_i (.sys_clk(sys_clk), .reset_n(reset_n), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .low_freq_clock(low_freq_clock), .pwm_out_pin_low(pwm_out_pin_low),
        .pwm_out_pin_high(pwm_out_pin_high), .unit_timer_irq_low(unit_timer_irq_low),
        .high_unit_timer_irq(high_unit_timer_irq));
    cpt_pwm_meter cpt_pwm_meter_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .pin_level(pwm_out_pin_low), .low_width(low_width), .period(period));
    ////////////////////////////////////////////////////////////////////////
    function automatic int pwm_low(input logic [7:0] d);
        return 255 - d;
    endfunction : pwm_low
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one classic cycle; read data is taken at the ack edge
    task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        wb_adr_i <= a;
        wb_we_i  <= w;
        wb_dat_i <= {24'h000000, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o[7:0];
        if (wb_ack_o !== 1'b1) n_mismatch++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb_xfer
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        wb_xfer(a, 1'b0, 8'h00);
        check({24'h0, rd}, {24'h0, exp});
    endtask : rd_chk
    // gap counted between two consecutive irqs, so prescaler phase drops out
    task automatic wait_irq(input int u);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((u ? high_unit_timer_irq : unit_timer_irq_low) !== 1'b1 && n < 20000);
        gap = 0;
        do begin
            @(posedge sys_clk);
            gap++;
        end while ((u ? high_unit_timer_irq : unit_timer_irq_low) !== 1'b1 && gap < 20000);
    endtask : wait_irq
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        slow_cnt <= (slow_cnt == 3'h4) ? 3'h0 : slow_cnt + 3'h1;
        if (slow_cnt == 3'h4) low_freq_clock <= ~low_freq_clock;
        if (cycles == 60000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        seed = 32'h24aa4ffd;
        {wb_we_i, wb_cyc_i, wb_stb_i, low_freq_clock, slow_cnt} = 7'h00;
        {wb_adr_i, wb_dat_i, wb_sel_i} = {8'h00, 32'h0, 4'hF};
        {n_mismatch, comparisons, cycles} = {32'd0, 32'd0, 32'd0};
        reset_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        check({30'h0, pwm_out_pin_low, pwm_out_pin_high}, 32'h3);
        rd_chk(CPT_ADDR_CTRL_LO, CPT_CTRL_RST);
        wb_xfer(8'h24, 1'b1, 8'h5A);
        rd_chk(8'h24, 8'h00);
        wb_sel_i <= 4'hE;
        wb_xfer(CPT_ADDR_CMP_LO, 1'b1, 8'hA5);
        wb_sel_i <= 4'hF;
        rd_chk(CPT_ADDR_CMP_LO, CPT_CMP_RST);
        $display("test reset and unmapped done");
        duty_a = 8'd2 + 8'($unsigned($random(seed)) % 253);
        wb_xfer(CPT_ADDR_DUTY_LO, 1'b1, duty_a);
        rd_chk(CPT_ADDR_DUTY_LO, duty_a);
        wb_xfer(CPT_ADDR_CTRL_LO, 1'b1, 8'h6A);
        wait_irq(0);
        check(gap, 256);
        repeat (2) @(posedge sys_clk);
        check(low_width, pwm_low(duty_a));
        check(period, 256);
        wb_xfer(CPT_ADDR_DUTY_LO, 1'b1, 8'hFE);
        rd_chk(CPT_ADDR_DUTY_LO, duty_a);
        wait_irq(0);
        rd_chk(CPT_ADDR_DUTY_LO, 8'hFE);
        check(low_width, pwm_low(8'hFE));
        $display("test pwm duty done");
        wb_xfer(CPT_ADDR_CTRL_LO, 1'b1, 8'h62);
        wb_xfer(CPT_ADDR_CTRL_LO, 1'b1, 8'hE2);
        @(posedge sys_clk);
        check(pwm_out_pin_low, 1'b0);
        wb_xfer(CPT_ADDR_CTRL_LO, 1'b1, 8'h62);
        @(posedge sys_clk);
        check(pwm_out_pin_low, 1'b1);
        $display("test stop and level done");
        wb_xfer(CPT_ADDR_DUTY_HI, 1'b1, 8'd2 + 8'($unsigned($random(seed)) % 253));
        for (int i = 0; i < 5; i++) begin
            wb_xfer(CPT_ADDR_CTRL_HI, 1'b1, {1'b0, srcs[i], 1'b1, CPT_MODE_PWM8});
            wait_irq(1);
            check(gap, 256 * divs[i]);
            wb_xfer(CPT_ADDR_CTRL_HI, 1'b1, 8'h00);
        end
        $display("test source clocks done");
        cmp = 16'h0100 + 16'($unsigned($random(seed)) % 128);
        wb_xfer(CPT_ADDR_CTRL_LO, 1'b1, 8'h33);
        wb_xfer(CPT_ADDR_CMP_LO, 1'b1, cmp[7:0]);
        wb_xfer(CPT_ADDR_CMP_HI, 1'b1, cmp[15:8]);
        wb_xfer(CPT_ADDR_CTRL_HI, 1'b1, 8'h08);
        wait_irq(1);
        check(gap, 8 * cmp);
        $display("test cascaded timer done");
        wb_xfer(CPT_ADDR_CTRL_HI, 1'b1, 8'h00);
        rd_chk(CPT_ADDR_COUNT_HI, CPT_CNT_RST);
        wb_xfer(CPT_ADDR_CTRL_LO, 1'b1, {1'b0, CPT_SRC_DIV2048, 1'b0, CPT_MODE_TIMER16});
        wb_xfer(CPT_ADDR_CMP_LO, 1'b1, 8'h10);
        wb_xfer(CPT_ADDR_CMP_HI, 1'b1, 8'h00);
        for (int c = 1; c < 3; c++) begin
            wb_xfer(CPT_ADDR_CLKCFG, 1'b1, 8'(c));
            rd_chk(CPT_ADDR_CLKCFG, 8'(c));
            wb_xfer(CPT_ADDR_CTRL_HI, 1'b1, 8'h08);
            wait_irq(1);
            check(gap, divs[3] * 8 * 16);
            wb_xfer(CPT_ADDR_CTRL_HI, 1'b1, 8'h00);
        end
        $display("test slow sources done");
        tally_and_finish();
    end
endmodule : tb_top
